// File: design/ielfs_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef IELFS_REGS_SVH
`define IELFS_REGS_SVH
`define IELFS_ADDR_FPCTX 32'hE000EF34
`define IELFS_ADDR_ACTLR 32'hE000E008
`define IELFS_ADDR_STAT 32'hE000EF40
`define IELFS_LAZY_BIT 30
`define IELFS_DISWB_BIT 1
`define IELFS_FPCTX_RST 32'h40000000
`define IELFS_ACTLR_RST 32'h00000000
`define IELFS_DIV_NS 112
`define IELFS_STACK_NS 96
`define IELFS_CLK_NS 8
`define IELFS_DIV_CYC ((`IELFS_DIV_NS + `IELFS_CLK_NS - 1) / `IELFS_CLK_NS)
`define IELFS_STACK_CYC ((`IELFS_STACK_NS + `IELFS_CLK_NS - 1) / `IELFS_CLK_NS)
`define IELFS_FP_WORDS 17
`endif

// File: design/ielfs_pkg.sv
// types for exception entry and lazy fp stacking
package ielfs_pkg;
  typedef enum logic [1:0] {
    IELFS_RUN,
    IELFS_STACK,
    IELFS_HANDLER,
    IELFS_RETURN
  } ielfs_state_t;
endpackage

// File: design/ielfs_div_unit.sv
// fp divide and square root iterative unit, fixed latency
`timescale 1ns/1ps
`include "ielfs_regs.svh"
module ielfs_div_unit (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [4:0] dest_in,
  input wire logic [31:0] result_in,
  input wire logic [4:0] flags_in,
  output logic busy,
  output logic done,
  output logic [4:0] dest,
  output logic [31:0] result,
  output logic [4:0] flags
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic busy_q;
  logic done_q;
  logic [4:0] dest_q;
  logic [31:0] res_q;
  logic [4:0] flg_q;
  wire last = busy_q && (cnt_q == 4'(`IELFS_DIV_CYC - 1));
  assign cnt_d = (start && !busy_q) ? 4'h1 : (busy_q ? cnt_q + 4'h1 : cnt_q);
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      dest_q <= 5'h00;
      res_q <= 32'h00000000;
      flg_q <= 5'h00;
    end else begin
      cnt_q <= cnt_d;
      done_q <= last;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        dest_q <= dest_in;
        res_q <= result_in;
        flg_q <= flags_in;
      end else if (last) begin
        busy_q <= 1'b0;
      end
    end
  end
  assign busy = busy_q;
  assign done = done_q;
  assign dest = dest_q;
  assign result = res_q;
  assign flags = flg_q;
endmodule

// File: design/ielfs_exc_unit.sv
// exception entry, lazy fp save, store buffer and return vector logic
// Operation
// - fp divide and square root deliver their result fourteen cycles after issue
// - interrupt entry never aborts a running divide; it finishes on its own count, during or after stacking
// - lazy mode defers fp register stacking until handler's first fp instruction
// - lazy saving is enabled after reset until software clears it
// - first handler instruction starts no sooner than twelve cycles after entry
// - lazy enable is bit 30 of fp context control; zero disables it
// - a one-entry store buffer lets execution continue while bus stalls
// - acknowledged interrupt and fetched vector always name the same interrupt
// - write buffer disable bit makes stores unbuffered, blocking exception return
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "ielfs_regs.svh"
module ielfs_exc_unit (
  input wire logic clk,
  input wire logic srst,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic irq_req,
  input wire logic [7:0] irq_sel,
  output logic irq_ack,
  output logic [7:0] irq_ack_id,
  output logic [7:0] vec_id,
  output logic vec_fetch,
  output logic handler_start,
  input wire logic exc_return,
  input wire logic handler_fp_insn,
  output logic fp_stall,
  output logic fp_save_req,
  input wire logic fp_save_done,
  input wire logic div_start,
  input wire logic [4:0] div_dest,
  input wire logic [31:0] div_value,
  input wire logic [4:0] div_flags,
  output logic div_busy,
  output logic fp_reg_we,
  output logic [4:0] fp_reg_dest,
  output logic [31:0] fp_reg_data,
  output logic fp_status_we,
  output logic [4:0] fp_status_flags,
  input wire logic st_valid,
  input wire logic [31:0] st_addr,
  input wire logic [31:0] st_data,
  output logic st_ready,
  output logic bus_st_valid,
  output logic [31:0] bus_st_addr,
  output logic [31:0] bus_st_data,
  input wire logic bus_st_ready,
  input wire logic sp_load_valid,
  input wire logic [31:0] sp_load_data,
  input wire logic sp_load_wb,
  input wire logic [31:0] sp_load_base,
  output logic [31:0] sp_value,
  output logic [31:0] base_value,
  output logic base_we
);
  ielfs_pkg::ielfs_state_t st_q;
  ielfs_pkg::ielfs_state_t st_d;
  logic lazy_en_q;
  logic diswb_q;
  logic [3:0] stk_q;
  logic lazy_pend_q;
  logic [7:0] irq_id_q;
  logic wb_full_q;
  logic [31:0] wb_addr_q;
  logic [31:0] wb_data_q;
  logic [31:0] rdata_q;
  logic [31:0] sp_q;
  logic [31:0] base_q;
  logic base_we_q;
  logic sp_done_q;
  logic ack_q;
  logic vec_q;
  logic hs_q;
  logic dv_done;
  logic [4:0] dv_dest;
  logic [31:0] dv_res;
  logic [4:0] dv_flg;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction

  wire wr_fpctx = reg_wr && hit(reg_addr, `IELFS_ADDR_FPCTX);
  wire wr_actlr = reg_wr && hit(reg_addr, `IELFS_ADDR_ACTLR);
  wire stack_end = (st_q == ielfs_pkg::IELFS_STACK) &&
                   (stk_q == 4'(`IELFS_STACK_CYC - 1));
  wire wb_drain = wb_full_q && bus_st_ready;
  wire wb_pass = diswb_q && st_valid && !wb_full_q;
  wire wb_take = !diswb_q && st_valid && (!wb_full_q || wb_drain);
  wire ret_ok = !wb_full_q && !(diswb_q && st_valid);
  wire take_irq = irq_req && ((st_q == ielfs_pkg::IELFS_RUN) ||
                  ((st_q == ielfs_pkg::IELFS_RETURN)));
  wire [31:0] rd_mux = hit(reg_addr, `IELFS_ADDR_FPCTX) ?
                       (32'(lazy_en_q) << `IELFS_LAZY_BIT) :
                       hit(reg_addr, `IELFS_ADDR_ACTLR) ?
                       (32'(diswb_q) << `IELFS_DISWB_BIT) :
                       hit(reg_addr, `IELFS_ADDR_STAT) ?
                       {28'h0000000, wb_full_q, lazy_pend_q, div_busy,
                        st_q != ielfs_pkg::IELFS_RUN} : 32'h00000000;

  ielfs_div_unit u_div (
    .clk(clk),
    .srst(srst),
    .start(div_start),
    .dest_in(div_dest),
    .result_in(div_value),
    .flags_in(div_flags),
    .busy(div_busy),
    .done(dv_done),
    .dest(dv_dest),
    .result(dv_res),
    .flags(dv_flg)
  );

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ielfs_pkg::IELFS_RUN: begin
        if (take_irq) st_d = ielfs_pkg::IELFS_STACK;
      end
      ielfs_pkg::IELFS_STACK: begin
        if (stack_end) st_d = ielfs_pkg::IELFS_HANDLER;
      end
      ielfs_pkg::IELFS_HANDLER: begin
        if (exc_return && !fp_stall) st_d = ielfs_pkg::IELFS_RETURN;
      end
      ielfs_pkg::IELFS_RETURN: begin
        if (take_irq) st_d = ielfs_pkg::IELFS_STACK;
        else if (ret_ok) st_d = ielfs_pkg::IELFS_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= ielfs_pkg::IELFS_RUN;
      lazy_en_q <= 1'((`IELFS_FPCTX_RST) >> `IELFS_LAZY_BIT);
      diswb_q <= 1'b0;
      stk_q <= 4'h0;
      lazy_pend_q <= 1'b0;
      irq_id_q <= 8'h00;
      ack_q <= 1'b0;
      vec_q <= 1'b0;
      hs_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      st_q <= st_d;
      ack_q <= take_irq && st_q != ielfs_pkg::IELFS_STACK;
      vec_q <= ack_q;
      hs_q <= stack_end;
      rdata_q <= reg_rd ? rd_mux : 32'h00000000;
      if (wr_fpctx) lazy_en_q <= reg_wdata[`IELFS_LAZY_BIT];
      if (wr_actlr) diswb_q <= reg_wdata[`IELFS_DISWB_BIT];
      if (take_irq) irq_id_q <= irq_sel;
      stk_q <= (st_q == ielfs_pkg::IELFS_STACK) ? stk_q + 4'h1 : 4'h0;
      if (take_irq) lazy_pend_q <= lazy_en_q;
      else if (lazy_pend_q && fp_save_done) lazy_pend_q <= 1'b0;
    end
  end

  // store buffer, one entry
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_full_q <= 1'b0;
      wb_addr_q <= 32'h00000000;
      wb_data_q <= 32'h00000000;
    end else begin
      if (wb_take) begin
        wb_full_q <= 1'b1;
        wb_addr_q <= st_addr;
        wb_data_q <= st_data;
      end else if (wb_drain) begin
        wb_full_q <= 1'b0;
      end
    end
  end

  // stack pointer load, committed once per data phase
  always_ff @(posedge clk) begin
    if (srst) begin
      sp_q <= 32'h00000000;
      base_q <= 32'h00000000;
      base_we_q <= 1'b0;
      sp_done_q <= 1'b0;
    end else begin
      base_we_q <= 1'b0;
      if (sp_load_valid && !sp_done_q) begin
        sp_q <= sp_load_data;
        sp_done_q <= 1'b1;
        if (sp_load_wb) begin
          base_q <= sp_load_base;
          base_we_q <= 1'b1;
        end
      end else if (!sp_load_valid) begin
        sp_done_q <= 1'b0;
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign irq_ack = ack_q;
  assign irq_ack_id = irq_id_q;
  assign vec_id = irq_id_q;
  assign vec_fetch = vec_q;
  assign handler_start = hs_q;
  assign fp_stall = lazy_pend_q && handler_fp_insn && !fp_save_done;
  assign fp_save_req = lazy_pend_q && handler_fp_insn;
  assign fp_reg_we = dv_done;
  assign fp_reg_dest = dv_dest;
  assign fp_reg_data = dv_res;
  assign fp_status_we = dv_done;
  assign fp_status_flags = dv_flg;
  // buffered entry drains first, even after the buffer is disabled
  assign st_ready = diswb_q ? (!wb_full_q && bus_st_ready) : (!wb_full_q || wb_drain);
  assign bus_st_valid = wb_full_q || wb_pass;
  assign bus_st_addr = wb_full_q ? wb_addr_q : st_addr;
  assign bus_st_data = wb_full_q ? wb_data_q : st_data;
  assign sp_value = sp_q;
  assign base_value = base_q;
  assign base_we = base_we_q;
endmodule

// File: test/ielfs_exc_unit_properties.sv
// checker on exception unit ports
`timescale 1ns/1ps
module ielfs_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic irq_ack,
  input wire logic vec_fetch,
  input wire logic handler_start,
  input wire logic handler_fp_insn,
  input wire logic fp_save_req,
  input wire logic div_start,
  input wire logic div_busy,
  input wire logic fp_reg_we,
  input wire logic fp_status_we,
  input wire logic sp_load_valid,
  input wire logic base_we,
  input wire logic bus_st_valid,
  input wire logic bus_st_ready,
  input wire logic [7:0] irq_ack_id,
  input wire logic [7:0] vec_id,
  input wire logic [31:0] bus_st_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_vec_after_ack: assert property (irq_ack |=> vec_fetch) else $error("no fetch");
  a_same_vec_id: assert property (vec_fetch |-> vec_id == irq_ack_id) else $error("id");
  a_ack_id_held: assert property (irq_ack |=> (!handler_start && $stable(irq_ack_id))[*8])
    else $error("id moved");
  a_handler_gap: assert property (irq_ack |-> ##12 handler_start) else $error("start");
  a_div_time: assert property (div_start && !div_busy |-> ##14 (fp_reg_we && fp_status_we))
    else $error("div");
  a_lazy_defer: assert property (fp_save_req |-> handler_fp_insn) else $error("save");
  a_sp_once: assert property (sp_load_valid && $past(sp_load_valid) |=> !base_we)
    else $error("sp twice");
  a_store_held: assert property (bus_st_valid && !bus_st_ready |=> $stable(bus_st_addr))
    else $error("store");
endmodule
bind ielfs_exc_unit ielfs_props u_props (.clk, .srst, .irq_ack, .vec_fetch, .handler_start,
  .handler_fp_insn, .fp_save_req, .div_start, .div_busy, .fp_reg_we, .fp_status_we,
  .sp_load_valid, .base_we, .bus_st_valid, .bus_st_ready, .irq_ack_id, .vec_id, .bus_st_addr);

// File: test/ielfs_partner.sv
// interrupt controller and store bus model
`timescale 1ns/1ps
module ielfs_partner (
  input wire logic clk,
  input wire logic srst,
  input wire logic raise,
  input wire logic irq_ack,
  input wire logic bus_st_valid,
  input wire logic [7:0] rid,
  input wire logic [3:0] stall,
  output logic irq_req,
  output logic bus_st_ready,
  output logic [7:0] irq_sel
);
  logic [3:0] wait_q;
  assign bus_st_ready = bus_st_valid && wait_q == stall;
  always_ff @(posedge clk) begin
    irq_req <= !srst && !irq_ack && (irq_req || raise);
    irq_sel <= srst ? 8'h00 : ((raise || irq_req) ? rid : ~irq_sel);
    wait_q <= (srst || !bus_st_valid || bus_st_ready) ? 4'h0 : wait_q + 4'h1;
  end
endmodule

// File: test/irq_entry_lazy_fp_stacking_tb.sv
// bench for exception entry, lazy fp save and store buffer
`timescale 1ns/1ps
module irq_entry_lazy_fp_stacking_tb;
  logic clk, srst, reg_wr, reg_rd, irq_req, irq_ack, vec_fetch, handler_start, exc_return, raise;
  logic handler_fp_insn, fp_stall, fp_save_req, fp_save_done, div_start, div_busy, fp_reg_we;
  logic fp_status_we, st_valid, st_ready, bus_st_valid, bus_st_ready, sp_load_valid, sp_load_wb;
  logic base_we;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, div_value, fp_reg_data, st_addr, st_data;
  logic [31:0] bus_st_addr, bus_st_data, sp_load_data, sp_load_base, sp_value, base_value;
  logic [7:0] irq_sel, irq_ack_id, vec_id, rid;
  logic [4:0] div_dest, div_flags, fp_reg_dest, fp_status_flags;
  logic [3:0] stall;
  int bad_count, total_checks, n;
  ielfs_exc_unit dut_u (.*);
  ielfs_partner peer_u (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task guard();
    chk(n < 40, 1'b1);
    if (n >= 40) conclude();
  endtask
  task wr(input logic [31:0] a, d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [31:0] a, e);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task t_regs();
    rd(32'hE000EF34, 32'h40000000);
    wr(32'hE000EF34, 32'h00000000);
    rd(32'hE000EF34, 32'h00000000);
    rd(32'hE000EF00, 32'h00000000);
    wr(32'hE000EF34, 32'h40000000);
  endtask
  task t_irq();
    @(posedge clk);
    {div_start, div_dest, div_value, div_flags} <= {1'b1, 5'h03, 32'h3F800000, 5'h11};
    {raise, rid} <= {1'b1, 8'h21};
    @(posedge clk);
    {div_start, raise} <= 2'h0;
    for (n = 0; n < 40 && fp_reg_we !== 1'b1; n++) @(posedge clk) #1;
    guard();
    chk(fp_reg_data, 32'h3F800000);
    chk(fp_reg_dest, 5'h03);
    chk(fp_status_flags, 5'h11);
    for (n = 0; n < 40 && handler_start !== 1'b1; n++) @(posedge clk) #1;
    guard();
    chk(vec_id, 8'h21);
    chk(irq_ack_id, 8'h21);
    chk(fp_save_req, 1'b0);
    @(posedge clk);
    handler_fp_insn <= 1'b1;
    @(posedge clk) #1;
    chk(fp_stall, 1'b1);
    @(posedge clk);
    fp_save_done <= 1'b1;
    @(posedge clk);
    fp_save_done <= 1'b0;
    #1;
    chk(fp_stall, 1'b0);
    @(posedge clk);
    {handler_fp_insn, exc_return} <= 2'h1;
    @(posedge clk);
    exc_return <= 1'b0;
    rd(32'hE000EF40, 32'h00000000);
  endtask
  task store(input logic [31:0] a, input logic thru);
    @(posedge clk);
    {st_valid, st_addr, st_data} <= {1'b1, a, ~a};
    #1;
    if (thru) begin
      chk(bus_st_valid, 1'b1);
      chk(bus_st_addr, a);
    end
    for (n = 0; n < 40 && st_ready !== 1'b1; n++) @(posedge clk) #1;
    guard();
    @(posedge clk);
    {st_valid, st_addr} <= {1'b0, ~a};
  endtask
  task t_store();
    store(32'h20000010, 1'b0);
    #1;
    chk(bus_st_addr, 32'h20000010);
    chk(bus_st_data, 32'hDFFFFFEF);
    chk(bus_st_valid && !bus_st_ready, 1'b1);
    rd(32'hE000EF40, 32'h00000008);
    wr(32'hE000E008, 32'h00000002);
    store(32'h20000020, 1'b1);
  endtask
  task t_sp();
    @(posedge clk);
    {sp_load_valid, sp_load_wb} <= 2'h3;
    {sp_load_data, sp_load_base} <= {32'h20001000, 32'h20000F00};
    repeat (3) @(posedge clk);
    sp_load_valid <= 1'b0;
    @(posedge clk) #1;
    chk(sp_value, 32'h20001000);
    chk(base_value, 32'h20000F00);
  endtask
  initial begin
    {reg_addr, reg_wdata, div_value, st_addr, st_data, sp_load_data, sp_load_base} = '0;
    {div_dest, div_flags, rid, raise, sp_load_valid, sp_load_wb, st_valid} = '0;
    {reg_wr, reg_rd, exc_return, handler_fp_insn, fp_save_done, div_start} = '0;
    stall = 4'h3;
    srst = 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_irq();
    t_store();
    t_sp();
    conclude();
  end
endmodule
